// ---- msc_pkg.sv ----
package msc_pkg;
    // registers sit at word index; byte address is index times four
    localparam logic [9:0] TXF_IDX     = 10'h132;
    localparam logic [9:0] RXF_IDX     = 10'h133;
    localparam logic [9:0] CFG0_IDX    = 10'h135;
    localparam logic [9:0] CFG1_IDX    = 10'h136;
    localparam logic [9:0] TUNE_LO_IDX = 10'h180;
    localparam logic [9:0] TUNE_HI_IDX = 10'h189;

    localparam int TX_EXCESSIVE_COLLISION_FLAG  = 5;
    localparam int TX_LATE_COLLISION_FLAG  = 4;
    localparam int TX_CRS   = 3;
    localparam int TX_JBR   = 2;
    localparam int TX_EMPTY = 1;
    localparam int TX_FULL  = 0;

    localparam int RX_WAKE = 7;
    localparam int RX_BUFF = 6;
    localparam int RX_LINK = 5;
    localparam int RX_RUNT = 4;
    localparam int RX_LONG = 3;
    localparam int RX_CRC  = 2;
    localparam int RX_FAE  = 1;
    localparam int RX_OK   = 0;

    localparam int C0_LAMP_POL = 7;
    localparam int C0_UNLOCK   = 6;
    localparam int C0_LINKDOWN_POWER_SAVE_N_N   = 3;
    localparam int C0_MEDIUM   = 2;
    localparam int C1_BWF      = 6;
    localparam int C1_MWF      = 5;
    localparam int C1_UWF      = 4;
    localparam int C1_LONG_B   = 1;
    localparam int C1_LONG_A   = 0;

    localparam logic [7:0] TX_STICKY = 8'h3C;
    localparam logic [7:0] RX_STICKY = 8'hBF;
    localparam logic [7:0] CFG0_MASK = 8'hCF;
    localparam logic [7:0] CFG1_MASK = 8'h73;
    localparam logic [7:0] CFG0_RST  = 8'h00;
    localparam logic [7:0] CFG1_RST  = 8'h00;
    localparam logic [7:0] FLAG_RST  = 8'h00;
    localparam logic [7:0] TUNE_RST  = 8'h00;

    localparam logic [12:0] RUNT_BYTES = 13'h0040;
    localparam logic [12:0] LONG_BYTES = 13'h1000;
    localparam logic [3:0]  AL_LAMP_IDX = 4'hA;
endpackage

// ---- msc_flags.sv ----
module msc_flags #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] f;
    } msc_flag_s;

    msc_flag_s q;
    msc_flag_s d;

    // set wins: an event on the clearing edge survives
    always_comb begin
        d   = q;
        d.f = (q.f & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q.f <= W'(msc_pkg::FLAG_RST);
        end else begin
            q <= d;
        end
    end

    assign flags = q.f;
endmodule

// ---- msc_tune.sv ----
module msc_tune #(
    parameter int unsigned N = 10
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           wr_en,
    input  wire logic [3:0]     wr_idx,
    input  wire logic [7:0]     wr_data,
    input  wire logic           ld_en,
    input  wire logic [3:0]     ld_idx,
    input  wire logic [7:0]     ld_data,
    input  wire logic [3:0]     rd_idx,
    output logic      [7:0]     rd_data,
    output logic      [N*8-1:0] tune
);
    typedef struct packed {
        logic [N*8-1:0] mem;
    } msc_tune_s;

    msc_tune_s q;
    msc_tune_s d;

    always_comb begin
        d = q;
        if (wr_en && wr_idx < 4'(N)) begin
            d.mem[wr_idx*8 +: 8] = wr_data;
        end
        // eeprom reload overrides a software write in the same cycle
        if (ld_en && ld_idx < 4'(N)) begin
            d.mem[ld_idx*8 +: 8] = ld_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q.mem <= {N{msc_pkg::TUNE_RST}};
        end else begin
            q <= d;
        end
    end

    assign rd_data = (rd_idx < 4'(N)) ? q.mem[rd_idx*8 +: 8] : 8'h00;
    assign tune    = q.mem;
endmodule

// ---- msc_status_config.sv ----
// Notes on behaviour
// - tx flags: collisions, carrier, jabber bits 5-2
// - tx buffer empty bit1, full bit0, live
// - tx flags clear on read or endpoint access
// - rx flags clear on read or endpoint access
// - rx bit7 set on wake event
// - rx buffer full bit6, link change bit5
// - frame under 64 bytes sets bit4
// - frame over 4k bytes sets bit3
// - frame check error sets bit2
// - alignment error sets bit1
// - error-free frame sets bit0
// - polarity zero: lamps driven high in suspend
// - tuning writes allowed only when unlocked
// - autoload reloads tuning bytes from eeprom
// - link down, bit3 zero: analog power down
// - medium bit one forces mii, phy off
// - medium read shows actual connection
// - lamp scheme field, default from eeprom
// - broadcast good frame wakes when enabled
// - hash-passing multicast wakes when enabled
// - own-address frame wakes when enabled
// - bit1 joins masks three, four
// - bit0 joins masks one, two
//
// Design decision made here: the Avalon-MM slave port.
module msc_status_config #(
    parameter int unsigned TUNE_N = 10
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [11:0]        avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               intr_ep_access,
    input  wire logic               tx_excess_coll,
    input  wire logic               tx_late_coll,
    input  wire logic               tx_carrier_lost,
    input  wire logic               tx_jabber,
    input  wire logic               tx_buf_empty,
    input  wire logic               tx_buf_full,
    input  wire logic               rx_buf_full,
    input  wire logic               link_change,
    input  wire logic               wake_other,
    input  wire logic               frame_done,
    input  wire logic [12:0]        frame_len,
    input  wire logic               frame_crc_err,
    input  wire logic               frame_align_err,
    input  wire logic               frame_bcast,
    input  wire logic               frame_mcast_hit,
    input  wire logic               frame_station_hit,
    input  wire logic               remote_wake_armed,
    input  wire logic               usb_suspend,
    input  wire logic               phy_link_ok,
    input  wire logic [3:0]         lamp_raw,
    input  wire logic               autoload_we,
    input  wire logic [3:0]         autoload_idx,
    input  wire logic [7:0]         autoload_data,
    output logic      [3:0]         lamp_out,
    output logic      [1:0]         lamp_scheme,
    output logic      [TUNE_N*8-1:0] analog_tune,
    output logic                    analog_power_down,
    output logic                    mii_select,
    output logic                    internal_phy_off,
    output logic                    wake_signal,
    output logic                    extended_wake_pattern_a,
    output logic                    extended_wake_pattern_b,
    output logic      [3:0]         wake_frame_disable
);
    typedef struct packed {
        logic       waitreq;
        logic [7:0] rdata;
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic       mii_sel;
        logic       pdown;
        logic [3:0] lamp;
        logic       wake;
        logic [3:0] wfdis;
    } msc_top_s;

    msc_top_s q;
    msc_top_s d;

    logic [9:0] widx;
    logic       req;
    logic       acc;
    logic       rd_acc;
    logic       wr_acc;
    logic [7:0] txf;
    logic [7:0] rxf;
    logic [7:0] tx_set;
    logic [7:0] rx_set;
    logic [7:0] tx_clr;
    logic [7:0] rx_clr;
    logic [7:0] rd_val;
    logic [7:0] tune_rd;
    logic [3:0] tune_idx;
    logic       runt;
    logic       long_f;
    logic       good;
    logic       wake_hit;
    logic       tune_we;

    function automatic logic in_tune(input logic [9:0] idx);
        return (idx >= msc_pkg::TUNE_LO_IDX)
            && (idx <= msc_pkg::TUNE_HI_IDX);
    endfunction

    assign widx     = avs_address[11:2];
    assign req      = avs_read | avs_write;
    assign acc      = req & ~q.waitreq;
    assign rd_acc   = acc & avs_read;
    assign wr_acc   = acc & avs_write;
    assign tune_idx = 4'(widx - msc_pkg::TUNE_LO_IDX);

    // frame classification
    assign runt   = frame_len < msc_pkg::RUNT_BYTES;
    assign long_f = frame_len > msc_pkg::LONG_BYTES;
    assign good   = ~frame_crc_err & ~frame_align_err & ~runt & ~long_f;

    assign wake_hit = frame_done & good & remote_wake_armed
        & ((frame_bcast & q.cfg1[msc_pkg::C1_BWF])
        | (frame_mcast_hit & q.cfg1[msc_pkg::C1_MWF])
        | (frame_station_hit & q.cfg1[msc_pkg::C1_UWF]));

    always_comb begin
        tx_set = 8'h00;
        tx_set[msc_pkg::TX_EXCESSIVE_COLLISION_FLAG] = tx_excess_coll;
        tx_set[msc_pkg::TX_LATE_COLLISION_FLAG] = tx_late_coll;
        tx_set[msc_pkg::TX_CRS]  = tx_carrier_lost;
        tx_set[msc_pkg::TX_JBR]  = tx_jabber;
        rx_set = 8'h00;
        rx_set[msc_pkg::RX_WAKE] = wake_hit | wake_other;
        rx_set[msc_pkg::RX_LINK] = link_change;
        rx_set[msc_pkg::RX_RUNT] = frame_done & runt;
        rx_set[msc_pkg::RX_LONG] = frame_done & long_f;
        rx_set[msc_pkg::RX_CRC]  = frame_done & frame_crc_err;
        rx_set[msc_pkg::RX_FAE]  = frame_done & frame_align_err;
        rx_set[msc_pkg::RX_OK]   = frame_done & good;
    end

    // a read clears only bits actually returned (endpoint access clears all sticky bits), so an event landing
    // between sampling and the accepting edge is kept for next read
    always_comb begin
        tx_clr = 8'h00;
        rx_clr = 8'h00;
        if (rd_acc && widx == msc_pkg::TXF_IDX) begin
            tx_clr = q.rdata & msc_pkg::TX_STICKY;
        end
        if (rd_acc && widx == msc_pkg::RXF_IDX) begin
            rx_clr = q.rdata & msc_pkg::RX_STICKY;
        end
        if (intr_ep_access) begin
            tx_clr = msc_pkg::TX_STICKY;
            rx_clr = msc_pkg::RX_STICKY;
        end
    end

    msc_flags #(
        .W (8)
    ) u_tx_flags (
        .clk   (clk),
        .rst   (rst),
        .set   (tx_set),
        .clr   (tx_clr),
        .flags (txf)
    );

    msc_flags #(
        .W (8)
    ) u_rx_flags (
        .clk   (clk),
        .rst   (rst),
        .set   (rx_set),
        .clr   (rx_clr),
        .flags (rxf)
    );

    assign tune_we = wr_acc && in_tune(widx)
        && q.cfg0[msc_pkg::C0_UNLOCK];

    msc_tune #(
        .N (TUNE_N)
    ) u_tune (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (tune_we),
        .wr_idx  (tune_idx),
        .wr_data (avs_writedata[7:0]),
        .ld_en   (autoload_we),
        .ld_idx  (autoload_idx),
        .ld_data (autoload_data),
        .rd_idx  (tune_idx),
        .rd_data (tune_rd),
        .tune    (analog_tune)
    );

    always_comb begin
        rd_val = 8'h00;
        case (widx)
            msc_pkg::TXF_IDX: begin
                rd_val = (txf & msc_pkg::TX_STICKY)
                    | {6'h00, tx_buf_empty, tx_buf_full};
            end
            msc_pkg::RXF_IDX: begin
                rd_val = rxf & msc_pkg::RX_STICKY;
                rd_val[msc_pkg::RX_BUFF] = rx_buf_full;
            end
            msc_pkg::CFG0_IDX: begin
                rd_val = q.cfg0 & msc_pkg::CFG0_MASK;
                rd_val[msc_pkg::C0_MEDIUM] = q.mii_sel;
            end
            msc_pkg::CFG1_IDX: begin
                rd_val = q.cfg1 & msc_pkg::CFG1_MASK;
            end
            default: begin
                rd_val = in_tune(widx) ? tune_rd : 8'h00;
            end
        endcase
    end

    always_comb begin
        d = q;
        // one wait state: sample on first edge, accept on second
        d.waitreq = 1'b1;
        if (req && q.waitreq) begin
            d.waitreq = 1'b0;
            d.rdata   = rd_val;
        end
        if (wr_acc && widx == msc_pkg::CFG0_IDX) begin
            d.cfg0 = avs_writedata[7:0] & msc_pkg::CFG0_MASK;
        end
        if (wr_acc && widx == msc_pkg::CFG1_IDX) begin
            d.cfg1 = avs_writedata[7:0] & msc_pkg::CFG1_MASK;
        end
        if (autoload_we && autoload_idx == msc_pkg::AL_LAMP_IDX) begin
            d.cfg0[1:0] = autoload_data[1:0];
        end
        // auto-detect falls back to mii when the phy has no link
        d.mii_sel = q.cfg0[msc_pkg::C0_MEDIUM] | ~phy_link_ok;
        // signal-detect and 100M receive are outside this switch
        d.pdown = ~phy_link_ok & ~q.cfg0[msc_pkg::C0_LINKDOWN_POWER_SAVE_N_N];
        if (usb_suspend && !q.cfg0[msc_pkg::C0_LAMP_POL]) begin
            d.lamp = 4'hF;
        end else begin
            d.lamp = lamp_raw;
        end
        d.wake  = wake_hit;
        d.wfdis = {q.cfg1[msc_pkg::C1_LONG_B],
                   q.cfg1[msc_pkg::C1_LONG_B],
                   q.cfg1[msc_pkg::C1_LONG_A],
                   q.cfg1[msc_pkg::C1_LONG_A]};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q.waitreq <= 1'b1;
            q.rdata   <= 8'h00;
            q.cfg0    <= msc_pkg::CFG0_RST;
            q.cfg1    <= msc_pkg::CFG1_RST;
            q.mii_sel <= 1'b0;
            q.pdown   <= 1'b0;
            q.lamp    <= 4'h0;
            q.wake    <= 1'b0;
            q.wfdis   <= 4'h0;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata            = {24'h000000, q.rdata};
    assign avs_waitrequest         = q.waitreq;
    assign lamp_out                = q.lamp;
    assign lamp_scheme             = q.cfg0[1:0];
    assign analog_power_down       = q.pdown;
    assign mii_select              = q.mii_sel;
    assign internal_phy_off        = q.cfg0[msc_pkg::C0_MEDIUM];
    assign wake_signal             = q.wake;
    assign extended_wake_pattern_a = q.cfg1[msc_pkg::C1_LONG_A];
    assign extended_wake_pattern_b = q.cfg1[msc_pkg::C1_LONG_B];
    assign wake_frame_disable      = q.wfdis;

    sequence s_good_bcast;
        frame_done && good && frame_bcast && remote_wake_armed
            && q.cfg1[msc_pkg::C1_BWF];
    endsequence

    sequence s_tx_read;
        rd_acc && widx == msc_pkg::TXF_IDX && tx_set == 8'h00
            && !intr_ep_access;
    endsequence

    a_bus_answer: assert property (
        @(posedge clk) disable iff (rst)
        (req && q.waitreq) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait state");

    a_tx_event_set: assert property (
        @(posedge clk) disable iff (rst)
        tx_excess_coll |=> txf[msc_pkg::TX_EXCESSIVE_COLLISION_FLAG])
        else $error("excess collision flag not set");

    a_tx_read_clear: assert property (
        @(posedge clk) disable iff (rst)
        s_tx_read |=> (txf & $past(q.rdata)) == 8'h00)
        else $error("tx flags not cleared by read");

    a_ep_clear_rx: assert property (
        @(posedge clk) disable iff (rst)
        (intr_ep_access && rx_set == 8'h00)
            |=> (rxf & msc_pkg::RX_STICKY) == 8'h00)
        else $error("rx flags not cleared by endpoint access");

    a_set_wins: assert property (
        @(posedge clk) disable iff (rst)
        (intr_ep_access && link_change) |=> rxf[msc_pkg::RX_LINK])
        else $error("event lost on clearing edge");

    a_runt_flag: assert property (
        @(posedge clk) disable iff (rst)
        (frame_done && frame_len < 13'h0040) |=> rxf[msc_pkg::RX_RUNT])
        else $error("short frame flag missing");

    a_long_flag: assert property (
        @(posedge clk) disable iff (rst)
        (frame_done && frame_len > 13'h1000) |=> rxf[msc_pkg::RX_LONG])
        else $error("oversize frame flag missing");

    a_good_no_err: assert property (
        @(posedge clk) disable iff (rst)
        (frame_done && frame_crc_err && !intr_ep_access)
            |=> $stable(rxf[msc_pkg::RX_OK]) || rxf[msc_pkg::RX_OK] == 1'b0)
        else $error("bad frame marked good");

    a_lamp_dark: assert property (
        @(posedge clk) disable iff (rst)
        (usb_suspend && !q.cfg0[msc_pkg::C0_LAMP_POL])
            |=> lamp_out == 4'hF)
        else $error("lamps not dark in suspend");

    a_tune_locked: assert property (
        @(posedge clk) disable iff (rst)
        (wr_acc && !q.cfg0[msc_pkg::C0_UNLOCK] && !autoload_we)
            |=> $stable(analog_tune))
        else $error("tuning changed while locked");

    a_power_down: assert property (
        @(posedge clk) disable iff (rst)
        (!phy_link_ok && !q.cfg0[msc_pkg::C0_LINKDOWN_POWER_SAVE_N_N]) [*2]
            |=> analog_power_down)
        else $error("no power down on link loss");

    a_medium_mii: assert property (
        @(posedge clk) disable iff (rst)
        internal_phy_off |=> mii_select)
        else $error("forced mii not reflected");

    a_bcast_wake: assert property (
        @(posedge clk) disable iff (rst)
        s_good_bcast |=> wake_signal && rxf[msc_pkg::RX_WAKE])
        else $error("broadcast wake missing");

    a_long_pattern: assert property (
        @(posedge clk) disable iff (rst)
        extended_wake_pattern_a |=> wake_frame_disable[1:0] == 2'h3)
        else $error("frames one and two not disabled");
endmodule

// ---- tb_msc_status_config.sv ----
module tb_msc_status_config;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_TX = {msc_pkg::TXF_IDX, 2'b00};
    localparam logic [11:0] A_RX = {msc_pkg::RXF_IDX, 2'b00};
    localparam logic [11:0] A_C0 = {msc_pkg::CFG0_IDX, 2'b00};
    localparam logic [11:0] A_C1 = {msc_pkg::CFG1_IDX, 2'b00};
    localparam logic [11:0] A_T0 = {msc_pkg::TUNE_LO_IDX, 2'b00};
    localparam logic [11:0] A_T9 = {msc_pkg::TUNE_HI_IDX, 2'b00};
    logic        clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, rdq;
    logic        intr_ep_access, tx_excess_coll, tx_late_coll, tx_jabber;
    logic        tx_carrier_lost, tx_buf_empty, tx_buf_full, rx_buf_full;
    logic        link_change, wake_other, frame_done, frame_crc_err;
    logic        frame_align_err, frame_bcast, frame_mcast_hit;
    logic        frame_station_hit, remote_wake_armed, usb_suspend;
    logic        phy_link_ok, autoload_we, mii_select, internal_phy_off;
    logic        analog_power_down, wake_signal, ext_a, ext_b;
    logic [12:0] frame_len;
    logic [3:0]  lamp_raw, autoload_idx, lamp_out, wake_frame_disable;
    logic [7:0]  autoload_data, v;
    logic [1:0]  lamp_scheme;
    logic [79:0] analog_tune;
    int          compares, miscompares, tx_m, rx_m, c0_m, c1_m;
    int          lens [6] = '{63, 64, 65, 4095, 4096, 4097};

    msc_status_config dut (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .intr_ep_access(intr_ep_access),
        .tx_excess_coll(tx_excess_coll), .tx_late_coll(tx_late_coll),
        .tx_carrier_lost(tx_carrier_lost), .tx_jabber(tx_jabber),
        .tx_buf_empty(tx_buf_empty), .tx_buf_full(tx_buf_full),
        .rx_buf_full(rx_buf_full), .link_change(link_change),
        .wake_other(wake_other), .frame_done(frame_done),
        .frame_len(frame_len), .frame_crc_err(frame_crc_err),
        .frame_align_err(frame_align_err), .frame_bcast(frame_bcast),
        .frame_mcast_hit(frame_mcast_hit),
        .frame_station_hit(frame_station_hit),
        .remote_wake_armed(remote_wake_armed), .usb_suspend(usb_suspend),
        .phy_link_ok(phy_link_ok), .lamp_raw(lamp_raw),
        .autoload_we(autoload_we), .autoload_idx(autoload_idx),
        .autoload_data(autoload_data), .lamp_out(lamp_out),
        .lamp_scheme(lamp_scheme), .analog_tune(analog_tune),
        .analog_power_down(analog_power_down), .mii_select(mii_select),
        .internal_phy_off(internal_phy_off), .wake_signal(wake_signal),
        .extended_wake_pattern_a(ext_a), .extended_wake_pattern_b(ext_b),
        .wake_frame_disable(wake_frame_disable)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // master holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk("wait_states", n, 2);
    endtask

    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, rdq, {24'h0, e});
    endtask

    task automatic rd_tx;
        rd("tx", A_TX, 8'(tx_m) | {6'h0, tx_buf_empty, tx_buf_full});
        tx_m = 0;
    endtask

    task automatic rd_rx;
        rd("rx", A_RX, 8'(rx_m) | {1'b0, rx_buf_full, 6'h0});
        rx_m = 0;
    endtask

    // e: endpoint, other wake, link, and four tx events
    task automatic pulse(input logic [6:0] e);
        @(posedge clk);
        {intr_ep_access, wake_other, link_change, tx_excess_coll,
         tx_late_coll, tx_carrier_lost, tx_jabber} <= e;
        @(posedge clk);
        {intr_ep_access, wake_other, link_change, tx_excess_coll,
         tx_late_coll, tx_carrier_lost, tx_jabber} <= 7'h00;
        if (e[6]) begin
            tx_m = 0;
            rx_m = 0;
        end
        tx_m = tx_m | (int'(e[3:0]) << 2);
        rx_m = rx_m | (int'(e[5]) << 7) | (int'(e[4]) << 5);
    endtask

    task automatic frame(input int len, input logic crc, input logic al,
                         input logic bc, input logic mc, input logic st);
        logic good, wk;
        @(posedge clk);
        // armed level is read only after pending updates have settled
        good = !crc && !al && len >= 64 && len <= 4096;
        wk = good && remote_wake_armed === 1'b1 && ((bc && c1_m[6])
             || (mc && c1_m[5]) || (st && c1_m[4]));
        frame_len <= 13'(len);
        frame_crc_err <= crc;
        frame_align_err <= al;
        frame_bcast <= bc;
        frame_mcast_hit <= mc;
        frame_station_hit <= st;
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        rx_m = rx_m | int'({wk, 2'b00, len < 64, len > 4096, crc, al, good});
        #1 chk("wake_signal", wake_signal, wk);
    endtask

    task automatic wr_c0(input logic [7:0] d);
        bus(1'b1, A_C0, d);
        c0_m = d & msc_pkg::CFG0_MASK;
    endtask

    task automatic autoload(input logic [3:0] i, input logic [7:0] d);
        @(posedge clk);
        autoload_we <= 1'b1;
        autoload_idx <= i;
        autoload_data <= d;
        @(posedge clk);
        autoload_we <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop;
    end

    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {intr_ep_access, tx_excess_coll, tx_late_coll, tx_carrier_lost} = '0;
        {tx_jabber, tx_buf_empty, tx_buf_full, rx_buf_full} = '0;
        {link_change, wake_other, frame_done, frame_len} = '0;
        {frame_crc_err, frame_align_err, frame_bcast, frame_mcast_hit} = '0;
        {frame_station_hit, remote_wake_armed, usb_suspend} = '0;
        {lamp_raw, autoload_we, autoload_idx, autoload_data} = '0;
        {compares, miscompares, tx_m, rx_m, c0_m, c1_m} = '0;
        phy_link_ok = 1'b1;
        seed = 32'h4A87;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_tx();
        rd_rx();
        rd("cfg0", A_C0, msc_pkg::CFG0_RST);
        rd("cfg1", A_C1, msc_pkg::CFG1_RST);
        bus(1'b1, 12'h4D0, 8'hFF);
        rd("unmapped", 12'h4D0, 8'h00);
        // each tx event alone, then all, with random live buffer levels
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            tx_buf_empty <= seed[0];
            tx_buf_full <= seed[1];
            rx_buf_full <= seed[2];
            pulse(i < 4 ? 7'(1 << i) : 7'h0F);
            rd_tx();
            rd_tx();
        end
        pulse(7'h3F);
        pulse(7'h40);
        rd_tx();
        rd_rx();
        pulse(7'h30);
        rd_rx();
        pulse(7'h3F);
        pulse(7'h50);
        rd_rx();
        foreach (lens[i]) begin
            frame(lens[i], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            rd_rx();
        end
        frame(100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        rd_rx();
        frame(100, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        rd_rx();
        frame(63, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        frame(5000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        rd_rx();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            frame(int'(seed[12:0]), seed[13] & seed[14], seed[15] & seed[16],
                  1'b0, 1'b0, 1'b0);
            rd_rx();
        end
        // config0 fields against link and suspend states
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            seed = lfsr(seed);
            v = i == 0 ? 8'hFF : (i == 1 ? 8'h00 : seed[7:0]);
            phy_link_ok <= i[0];
            usb_suspend <= i[1];
            lamp_raw <= seed[11:8];
            wr_c0(v);
            rd("cfg0", A_C0,
               8'(c0_m) & 8'hFB | {5'h0, v[2] | !i[0], 2'h0});
            #1 chk("lamp_scheme", lamp_scheme, v[1:0]);
            chk("phy_off", internal_phy_off, v[2]);
            chk("mii_select", mii_select, v[2] | !i[0]);
            chk("power_down", analog_power_down, !i[0] & !v[3]);
            chk("lamp_out", lamp_out,
                i[1] & !v[7] ? 4'hF : seed[11:8]);
        end
        // tuning bytes locked, unlocked, then reloaded
        wr_c0(8'h00);
        bus(1'b1, A_T0, 8'h5A);
        rd("tune0", A_T0, msc_pkg::TUNE_RST);
        wr_c0(8'h40);
        bus(1'b1, A_T0, 8'h5A);
        bus(1'b1, A_T9, 8'hC3);
        rd("tune0", A_T0, 8'h5A);
        #1 chk("tune_hi", analog_tune[79:72], 8'hC3);
        autoload(4'h9, 8'h3C);
        autoload(msc_pkg::AL_LAMP_IDX, 8'h03);
        rd("tune9", A_T9, 8'h3C);
        rd("cfg0", A_C0, 8'h43);
        // wake configuration
        foreach (lens[i]) begin
            v = i[0] ? 8'h01 : (i[1] ? 8'h02 : 8'hFF);
            bus(1'b1, A_C1, v);
            c1_m = v & msc_pkg::CFG1_MASK;
            rd("cfg1", A_C1, 8'(c1_m));
            #1 chk("ext_a", ext_a, v[0]);
            chk("ext_b", ext_b, v[1]);
            chk("wf_dis", wake_frame_disable, {{2{v[1]}}, {2{v[0]}}});
        end
        @(posedge clk) remote_wake_armed <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            v = 8'(1 << (4 + i));
            bus(1'b1, A_C1, v);
            c1_m = v;
            frame(100, 1'b0, 1'b0, i == 2, i == 1, i == 0);
            frame(100, 1'b0, 1'b0, i != 2, i != 1, i != 0);
            rd_rx();
        end
        bus(1'b1, A_C1, 8'h70);
        c1_m = 8'h70;
        frame(100, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        @(posedge clk) remote_wake_armed <= 1'b0;
        frame(100, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        rd_rx();
        report_and_stop;
    end
endmodule
